// File: trailer_pkg.sv
// Package of constants for the image trailer chunk generator
`default_nettype none
package trailer_pkg;
    // ---------------------------------------------------------------
    // Register map (byte offsets)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL       = 8'h00;
    localparam logic [7:0] ADDR_SELECT     = 8'h04;
    localparam logic [7:0] ADDR_ENABLE     = 8'h08;
    localparam logic [7:0] ADDR_TICK_FREQ  = 8'h0C;
    localparam logic [7:0] ADDR_TICK_LO    = 8'h10;
    localparam logic [7:0] ADDR_TICK_HI    = 8'h14;
    localparam logic [7:0] ADDR_STATUS     = 8'h18;
    // ---------------------------------------------------------------
    // Fields and encodings
    // ---------------------------------------------------------------
    localparam int         CTRL_ATTACH_BIT = 0;
    localparam int         EN_STAMP_BIT    = 0;
    localparam int         EN_LINES_BIT    = 1;
    localparam int         EN_CHECK_BIT    = 2;
    localparam int         EN_EXTDATA_BIT  = 3;
    localparam logic [1:0] KIND_STAMP      = 2'h0;
    localparam logic [1:0] KIND_LINES      = 2'h1;
    localparam logic [1:0] KIND_CHECK      = 2'h2;
    localparam int         STAMP_WIDTH     = 64;
    localparam int         SNAP_WIDTH      = 32;
    localparam int         CHECK_WIDTH     = 16;
    localparam logic [15:0] CHECK_POLY     = 16'h1021;
    localparam logic [15:0] CHECK_INIT     = 16'h0000;
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int          TICK_PERIOD_NS = 8;
    localparam logic [31:0] TICK_FREQ_HZ   = 32'(1000000000 / TICK_PERIOD_NS);
    typedef enum logic [2:0] {
        ST_IMAGE, ST_STAMP, ST_LINES, ST_CHECK
    } frame_state_t;
endpackage
`default_nettype wire

// File: image_trailer_chunk_gen.sv
// Image trailer chunk generator with AXI4-Lite control
// Overview of operation
// - Latch tick count at acquisition trigger
// - Time stamp is unsigned 64 bits
// - Count 8 ns ticks, report tick rate
// - Tick counter restarts at reset
// - Kind enable refused while attach off
// - Attach off clears every kind enable
// - Select kind, then set its enable
// - Enabled kinds appended to later images
// - Sample all pin levels at trigger; only pins with a set PIN_MAP bit are sampled, others read 0
// - Pin snapshot field is 32 bits
// - Bit holds line level at trigger
// - Checksum chunk is Z-modem CRC
// - Checksum covers image and other chunks
// - Checksum chunk always placed last
// - Attach on enables extended data chunk; the code only sets enable bit 3 and never emits such a chunk
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`default_nettype none
module image_trailer_chunk_gen
    import trailer_pkg::*;
#(
    parameter int                NUM_PINS = 8,
    parameter logic [31:0]       PIN_MAP  = 32'h000000FF
) (
    // Clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // Trigger and pin levels
    input  wire logic                trigger,
    input  wire logic [NUM_PINS-1:0] pin_levels,
    // Image input stream (bytes)
    input  wire logic [7:0]          in_data,
    input  wire logic                in_valid,
    input  wire logic                in_last,
    output logic                     in_ready,
    // Output stream (bytes)
    output logic [7:0]               out_data,
    output logic                     out_valid,
    output logic                     out_last,
    input  wire logic                out_ready
);
    import trailer_pkg::*;

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    logic [2:0]          trig_sync;
    logic [NUM_PINS-1:0] pin_s1, pin_s2, pin_s3;
    logic                trig_seen;
    logic                trig_event;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_sync <= 3'h0;
            pin_s1    <= '0;
            pin_s2    <= '0;
            pin_s3    <= '0;
            trig_seen <= 1'b0;
        end else begin
            trig_sync <= {trig_sync[1:0], trigger};
            pin_s1    <= pin_levels;
            pin_s2    <= pin_s1;
            pin_s3    <= pin_s2;
            if (trig_sync[1] == trig_sync[2])
                trig_seen <= trig_sync[2];
        end
    end
    assign trig_event = (trig_sync[1] == trig_sync[2]) && trig_sync[2] && !trig_seen;

    // ---------------------------------------------------------------
    // Tick counter and trigger latches
    // ---------------------------------------------------------------
    logic [STAMP_WIDTH-1:0] tick_count, next_tick_count;
    logic [STAMP_WIDTH-1:0] stamp_latch, next_stamp_latch;
    logic [SNAP_WIDTH-1:0]  snap_latch, next_snap_latch;
    logic [SNAP_WIDTH-1:0]  snap_now;
    always_comb begin
        for (int i = 0; i < SNAP_WIDTH; i++) begin
            snap_now[i] = 1'b0;
            if (PIN_MAP[i] && i < NUM_PINS)
                snap_now[i] = pin_s3[i % NUM_PINS];
        end
    end
    always_comb begin
        next_tick_count  = tick_count + 64'h1;
        next_stamp_latch = stamp_latch;
        next_snap_latch  = snap_latch;
        if (trig_event) begin
            next_stamp_latch = tick_count;
            next_snap_latch  = snap_now;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_count  <= '0;
            stamp_latch <= '0;
            snap_latch  <= '0;
        end else begin
            tick_count  <= next_tick_count;
            stamp_latch <= next_stamp_latch;
            snap_latch  <= next_snap_latch;
        end
    end

    // ---------------------------------------------------------------
    // Control registers and AXI4-Lite
    // ---------------------------------------------------------------
    logic       attach, next_attach;
    logic [1:0] kind_sel, next_kind_sel;
    logic [3:0] kind_en, next_kind_en;
    logic       aw_held, next_aw_held, w_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic       bvalid, next_bvalid, rvalid, next_rvalid;
    logic [1:0] bresp, next_bresp, rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic       busy;
    function automatic logic addr_known(input logic [7:0] a);
        return a == ADDR_CTRL || a == ADDR_SELECT || a == ADDR_ENABLE || a == ADDR_TICK_FREQ
            || a == ADDR_TICK_LO || a == ADDR_TICK_HI || a == ADDR_STATUS;
    endfunction
    assign s_axi_awready = !aw_held && !bvalid;
    assign s_axi_wready  = !w_held && !bvalid;
    assign s_axi_arready = !rvalid;
    always_comb begin
        logic [7:0]  wa;
        logic [31:0] wd;
        wa = aw_held ? aw_addr : s_axi_awaddr;
        wd = w_held ? w_data : s_axi_wdata;
        next_attach   = attach;
        next_kind_sel = kind_sel;
        next_kind_en  = kind_en;
        next_aw_held  = aw_held || (s_axi_awvalid && s_axi_awready);
        next_w_held   = w_held || (s_axi_wvalid && s_axi_wready);
        next_aw_addr  = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr;
        next_w_data   = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_data;
        next_bvalid   = bvalid && !s_axi_bready;
        next_bresp    = bresp;
        next_rvalid   = rvalid && !s_axi_rready;
        next_rresp    = rresp;
        next_rdata    = rdata;
        if (next_aw_held && next_w_held && !bvalid) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = addr_known(wa) ? RESP_OKAY : RESP_SLVERR;
            if (s_axi_wstrb[0]) begin
                case (wa)
                    ADDR_CTRL: begin
                        next_attach = wd[CTRL_ATTACH_BIT];
                        if (wd[CTRL_ATTACH_BIT])
                            next_kind_en[EN_EXTDATA_BIT] = 1'b1;
                        else
                            next_kind_en = 4'h0;
                    end
                    ADDR_SELECT: next_kind_sel = wd[1:0];
                    ADDR_ENABLE: begin
                        if (attach && kind_sel <= KIND_CHECK)
                            next_kind_en[kind_sel] = wd[0];
                    end
                    default: ;
                endcase
            end
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                ADDR_CTRL:      next_rdata = {31'h0, attach};
                ADDR_SELECT:    next_rdata = {30'h0, kind_sel};
                ADDR_ENABLE:    next_rdata = {31'h0, kind_sel <= KIND_CHECK ? kind_en[kind_sel] : 1'b0};
                ADDR_TICK_FREQ: next_rdata = TICK_FREQ_HZ;
                ADDR_TICK_LO:   next_rdata = stamp_latch[31:0];
                ADDR_TICK_HI:   next_rdata = stamp_latch[63:32];
                ADDR_STATUS:    next_rdata = {27'h0, busy, kind_en};
                default:        next_rdata = 32'h0;
            endcase
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            attach   <= 1'b0;
            kind_sel <= 2'h0;
            kind_en  <= 4'h0;
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            aw_addr  <= 8'h0;
            w_data   <= 32'h0;
            bvalid   <= 1'b0;
            bresp    <= 2'h0;
            rvalid   <= 1'b0;
            rresp    <= 2'h0;
            rdata    <= 32'h0;
        end else begin
            attach   <= next_attach;
            kind_sel <= next_kind_sel;
            kind_en  <= next_kind_en;
            aw_held  <= next_aw_held;
            w_held   <= next_w_held;
            aw_addr  <= next_aw_addr;
            w_data   <= next_w_data;
            bvalid   <= next_bvalid;
            bresp    <= next_bresp;
            rvalid   <= next_rvalid;
            rresp    <= next_rresp;
            rdata    <= next_rdata;
        end
    end
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp  = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rresp  = rresp;
    assign s_axi_rdata  = rdata;

    // ---------------------------------------------------------------
    // Framer: image, stamp, snapshot, checksum
    // ---------------------------------------------------------------
    frame_state_t state, next_state;
    logic [3:0]   frame_en, next_frame_en;
    logic [2:0]   idx, next_idx;
    logic [15:0]  crc, next_crc;
    logic [7:0]   byte_now;
    logic         fire;
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int k = 0; k < 8; k++)
            r = r[15] ? ((r << 1) ^ CHECK_POLY) : (r << 1);
        return r;
    endfunction
    assign busy = state != ST_IMAGE;
    assign in_ready = (state == ST_IMAGE) && out_ready;
    always_comb begin
        case (state)
            ST_STAMP: byte_now = stamp_latch[8*idx +: 8];
            ST_LINES: byte_now = snap_latch[8*idx[1:0] +: 8];
            ST_CHECK: byte_now = idx[0] ? crc[7:0] : crc[15:8];
            default:  byte_now = in_data;
        endcase
    end
    always_comb begin
        out_data  = byte_now;
        out_valid = (state == ST_IMAGE) ? in_valid : 1'b1;
        fire      = out_valid && out_ready;
        out_last  = 1'b0;
        next_state    = state;
        next_frame_en = frame_en;
        next_idx      = idx;
        next_crc      = crc;
        case (state)
            ST_IMAGE: begin
                if (fire) begin
                    next_crc = crc_step(crc, in_data);
                    if (in_last) begin
                        next_frame_en = kind_en;
                        next_idx      = 3'h0;
                        if (kind_en[EN_STAMP_BIT]) next_state = ST_STAMP;
                        else if (kind_en[EN_LINES_BIT]) next_state = ST_LINES;
                        else if (kind_en[EN_CHECK_BIT]) next_state = ST_CHECK;
                        else next_crc = CHECK_INIT;
                    end
                end
                out_last = in_valid && in_last && !(|kind_en[2:0]);
            end
            ST_STAMP: begin
                out_last = !frame_en[EN_LINES_BIT] && !frame_en[EN_CHECK_BIT] && idx == 3'h7;
                if (fire) begin
                    next_crc = crc_step(crc, byte_now);
                    next_idx = idx + 3'h1;
                    if (idx == 3'h7) begin
                        next_idx = 3'h0;
                        if (frame_en[EN_LINES_BIT]) next_state = ST_LINES;
                        else if (frame_en[EN_CHECK_BIT]) next_state = ST_CHECK;
                        else begin next_state = ST_IMAGE; next_crc = CHECK_INIT; end
                    end
                end
            end
            ST_LINES: begin
                out_last = !frame_en[EN_CHECK_BIT] && idx == 3'h3;
                if (fire) begin
                    next_crc = crc_step(crc, byte_now);
                    next_idx = idx + 3'h1;
                    if (idx == 3'h3) begin
                        next_idx = 3'h0;
                        if (frame_en[EN_CHECK_BIT]) next_state = ST_CHECK;
                        else begin next_state = ST_IMAGE; next_crc = CHECK_INIT; end
                    end
                end
            end
            ST_CHECK: begin
                out_last = idx == 3'h1;
                if (fire) begin
                    next_idx = idx + 3'h1;
                    if (idx == 3'h1) begin
                        next_idx   = 3'h0;
                        next_state = ST_IMAGE;
                        next_crc   = CHECK_INIT;
                    end
                end
            end
            default: next_state = ST_IMAGE;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state    <= ST_IMAGE;
            frame_en <= 4'h0;
            idx      <= 3'h0;
            crc      <= CHECK_INIT;
        end else begin
            state    <= next_state;
            frame_en <= next_frame_en;
            idx      <= next_idx;
            crc      <= next_crc;
        end
    end
endmodule // image_trailer_chunk_gen
`default_nettype wire

// File: image_trailer_chunk_gen_assertions.sv
// Port-level checker for the image trailer chunk generator
`default_nettype none
module image_trailer_chunk_gen_assertions
    import trailer_pkg::*;
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    // Streams
    input wire logic [7:0]  in_data,
    input wire logic        in_valid,
    input wire logic        in_ready,
    input wire logic [7:0]  out_data,
    input wire logic        out_valid,
    input wire logic        out_last,
    input wire logic        out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    freq_read_a: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_TICK_FREQ
        |=> s_axi_rvalid && s_axi_rdata == TICK_FREQ_HZ) else $error("tick rate read wrong");
    write_answer_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write response missing");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read response missing");
    unmapped_read_a: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_STATUS
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
    pass_through_a: assert property (
        in_valid && in_ready |-> out_valid && out_data == in_data) else $error("image byte altered");
    ready_link_a: assert property (
        in_ready |-> out_ready) else $error("input taken while output stalled");
    trailer_hold_a: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_data)) else $error("output byte dropped");
    last_valid_a: assert property (
        out_last |-> out_valid) else $error("last flag without data");
    cover property (out_valid && out_last && out_ready);
    cover property (out_valid && !out_ready);
    cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule // image_trailer_chunk_gen_assertions
`default_nettype wire

// File: host_stream_sink.sv
// Host model that collects the output stream, stalls and recomputes sums for the bench
`default_nettype none
module host_stream_sink (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Stream from the block
    input  wire logic [7:0] out_data,
    input  wire logic       out_valid,
    input  wire logic       out_last,
    output logic            out_ready,
    // Stall control
    input  wire logic       slow
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx_q[$];
    logic       last_q[$];
    logic [1:0] ph;
    // Receiver recomputes the checksum
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'h0000;
        foreach (q[i]) begin
            c = c ^ {q[i], 8'h00};
            for (int b = 0; b < 8; b++) c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
        end
        return c;
    endfunction
    assign out_ready = !slow || ph == 2'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ph <= 2'h0;
        end else begin
            ph <= ph + 2'h1;
        end
    end
    // Capture; the bench empties these queues
    always @(posedge aclk) begin
        if (aresetn && out_valid && out_ready) begin
            rx_q.push_back(out_data);
            last_q.push_back(out_last);
        end
    end
endmodule // host_stream_sink
`default_nettype wire

// File: image_trailer_chunk_gen_tb_top.sv
// Testbench top for the image trailer chunk generator
`default_nettype none
module image_trailer_chunk_gen_tb_top
    import trailer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, trigger, slow, in_valid, in_last, in_ready, out_valid, out_last, out_ready;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, pin_levels, in_data, out_data;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, wr_resp;
    int          fails, n_compared;
    image_trailer_chunk_gen image_trailer_chunk_gen_i (.*);
    host_stream_sink host_stream_sink_i (.*);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic st(input logic [3:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(ADDR_STATUS, d, r);
        chk(64'(d[3:0]), 64'(e));
    endtask
    task automatic trig(input logic [7:0] p, output logic [63:0] s);
        logic [31:0] lo, hi;
        logic [1:0]  r;
        @(posedge aclk);
        pin_levels <= p;
        trigger <= 1'b1;
        repeat (8) @(posedge aclk);
        trigger <= 1'b0;
        pin_levels <= ~p;
        rd(ADDR_TICK_LO, lo, r);
        rd(ADDR_TICK_HI, hi, r);
        s = {hi, lo};
    endtask
    task automatic frame(input int n, input logic [7:0] b0, input logic [2:0] en, input logic [63:0] s,
                         input logic [31:0] sn);
        logic [7:0]  e[$];
        logic [15:0] c;
        int          t;
        for (int i = 0; i < n; i++) e.push_back(b0 + 8'(i));
        if (en[0]) for (int i = 0; i < 8; i++) e.push_back(s[8*i +: 8]);
        if (en[1]) for (int i = 0; i < 4; i++) e.push_back(sn[8*i +: 8]);
        c = host_stream_sink_i.crc16(e);
        if (en[2]) e = {e, c[15:8], c[7:0]};
        @(posedge aclk);
        in_valid <= 1'b1;
        for (int i = 0; i < n; i++) begin
            in_data <= b0 + 8'(i);
            in_last <= (i == n - 1);
            do @(posedge aclk); while (!in_ready);
        end
        in_valid <= 1'b0;
        in_last <= 1'b0;
        t = 0;
        while (host_stream_sink_i.rx_q.size() < e.size() && t < 300) begin
            @(posedge aclk);
            t++;
        end
        repeat (4) @(posedge aclk);
        chk(64'(host_stream_sink_i.rx_q.size()), 64'(e.size()));
        foreach (host_stream_sink_i.rx_q[i])
            chk({host_stream_sink_i.rx_q[i], host_stream_sink_i.last_q[i]}, {e[i], i == e.size() - 1});
        host_stream_sink_i.rx_q.delete();
        host_stream_sink_i.last_q.delete();
    endtask
    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [63:0] s0, s1;
        {aresetn, trigger, slow, in_valid, in_last, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {pin_levels, in_data, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        trig(8'h00, s0);
        chk(64'(s0[63:6]), 64'h0);
        rd(ADDR_TICK_FREQ, d, r);
        chk(64'(d), 64'(TICK_FREQ_HZ));
        rd(8'h40, d, r);
        chk({r, d}, {RESP_SLVERR, 32'h0});
        wr(8'h40, 32'h1);
        chk(64'(wr_resp), 64'(RESP_SLVERR));
        wr(ADDR_SELECT, 32'(KIND_STAMP));
        chk(64'(wr_resp), 64'(RESP_OKAY));
        wr(ADDR_ENABLE, 32'h1);
        st(4'h0);
        wr(ADDR_CTRL, 32'h1);
        st(4'h8);
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_SELECT, 32'(k));
            wr(ADDR_ENABLE, 32'h1);
        end
        st(4'hF);
        rd(ADDR_ENABLE, d, r);
        chk(64'(d), 64'h1);
        wr(ADDR_SELECT, 32'h3);
        wr(ADDR_ENABLE, 32'h0);
        s_axi_wstrb <= 4'hE;
        wr(ADDR_CTRL, 32'h0);
        s_axi_wstrb <= 4'hF;
        st(4'hF);
        trig(8'hA5, s0);
        frame(6, 8'h10, 3'b111, s0, 32'h000000A5);
        wr(ADDR_SELECT, 32'(KIND_LINES));
        wr(ADDR_ENABLE, 32'h0);
        slow <= 1'b1;
        trig(8'h3C, s1);
        chk(64'(s1 > s0), 64'h1);
        frame(5, 8'hFE, 3'b101, s1, 32'h0);
        wr(ADDR_CTRL, 32'h0);
        st(4'h0);
        wr(ADDR_SELECT, 32'(KIND_STAMP));
        wr(ADDR_ENABLE, 32'h1);
        st(4'h0);
        frame(4, 8'h00, 3'b000, 64'h0, 32'h0);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        trig(8'h00, s0);
        chk(64'(s0[63:6]), 64'h0);
        st(4'h0);
        test_done;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        $display("watchdog expired at %0t", $time);
        test_done;
    end
endmodule // image_trailer_chunk_gen_tb_top
bind image_trailer_chunk_gen image_trailer_chunk_gen_assertions image_trailer_chunk_gen_assertions_i (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp,
    .in_data, .in_valid, .in_ready, .out_data, .out_valid, .out_last, .out_ready);
`default_nettype wire
